// ==== hdl/rvq_defines.svh ====
`ifndef RVQ_DEFINES_SVH
`define RVQ_DEFINES_SVH

// Register offsets on the register port.
`define RVQ_TRUNC_CFG_ADDR 8'h7C
`define RVQ_QUAL_CTL_ADDR 8'h7D
`define RVQ_STATUS_ADDR 8'h7E

// Reset values.
`define RVQ_TRUNC_CFG_RST 8'h00
`define RVQ_QUAL_CTL_RST 8'h00

// Truncation configuration fields.
`define RVQ_TRUNC_LINE_BIT 0
`define RVQ_TRUNC_FRAME_BIT 1
`define RVQ_TRUNC_CSI_PAR_BIT 2

// Qualification control fields.
`define RVQ_THRESH_LSB 0
`define RVQ_THRESH_MSB 1
`define RVQ_QUAL_LINE_SIZE_BIT 2
`define RVQ_QUAL_LINES_BIT 3
`define RVQ_QUAL_PARITY_BIT 4
`define RVQ_DISCARD_EN_BIT 5

// Status fields.
`define RVQ_STS_PASS_BIT 0
`define RVQ_STS_CNT_LSB 1
`define RVQ_STS_CNT_MSB 2
`define RVQ_STS_STICKY_LSB 3
`define RVQ_STS_STICKY_MSB 6
`define RVQ_STS_LOCK_BIT 7

// Sticky flag positions inside the sticky field.
`define RVQ_FLG_LINE_LEN 0
`define RVQ_FLG_LINE_CNT 1
`define RVQ_FLG_PARITY 2
`define RVQ_FLG_TRUNC 3

`endif

// ==== hdl/rvq_pkg.sv ====
package rvq_pkg;

  // Kind of item carried on the video stream.
  typedef enum logic [1:0] {
    RVQ_ITEM_DATA,
    RVQ_ITEM_FRAME_START,
    RVQ_ITEM_LINE_END,
    RVQ_ITEM_FRAME_END
  } rvq_item_e;

  typedef logic [7:0] rvq_byte_t;

endpackage : rvq_pkg

// ==== hdl/rvq_qualifier.sv ====
// Behaviour
// - On a video error, flag it and cut short the frame being forwarded.
// - After an error, restart forwarding at the next frame start.
// - With discard enabled, drop all input until pass is shown.
// - Truncation triggers: line size, frame size, CSI parity, each enabled separately.
// - Size-mismatch truncation stops the frame at once without frame end.
// - Truncate after any number of lines; truncated frame never sends frame end.
// - Threshold field selects zero to three valid frames before pass.
// - Threshold zero: pass follows receiver lock.
// - Nonzero threshold: pass after that many consecutive valid frames.
// - Parity qualification on: pass returns one frame early after parity error.
// - Line size check: all lines equal in and across frames.
// - Line length change restarts the valid frame counter and flags it.
// - Lines per frame check: line count change restarts the counter.
// - Parity qualification: link parity error drops pass and clears counter.
// - Pass deassertion is reported as an event for the transmit port.
`include "rvq_defines.svh"
`timescale 1ns/1ps

module rvq_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [LW-1:0] cnt;
  } rvq_fifo_s;

  rvq_fifo_s s_q;
  rvq_fifo_s s_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("rvq_fifo depth must be a power of two of at least two");
  end

  assign in_ready = s_q.cnt != LW'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rd];
  assign level = s_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + PW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + PW'(1);
    end
    s_d.cnt = s_q.cnt + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rvq_fifo

module rvq_qualifier #(
  parameter int LEN_W = 16,
  parameter int LINES_W = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_lock,
  input wire logic link_par_err,
  input wire logic csi_par_err,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_type,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_type,
  output logic [7:0] out_data,
  output logic pass,
  output logic pass_lost
);
  localparam int IW = 10;
  localparam int FLW = $clog2(FIFO_DEPTH+1);

  if (LEN_W < 2 || LINES_W < 2) begin : g_chk
    $error("rvq_qualifier counter widths must be at least two");
  end

  typedef struct packed {
    logic [7:0] trunc_cfg;
    logic [7:0] qual_ctl;
    logic [3:0] sticky;
    logic [1:0] cnt;
    logic pass;
    logic par_recov;
    logic [LEN_W-1:0] line_len;
    logic [LEN_W-1:0] ref_len;
    logic ref_len_ok;
    logic [LINES_W-1:0] line_no;
    logic [LINES_W-1:0] ref_lines;
    logic ref_lines_ok;
    logic frame_bad;
    logic in_frame;
    logic fwd;
    logic in_ready;
    logic push;
    logic [IW-1:0] push_item;
    logic [7:0] rdata;
    logic pass_lost;
  } rvq_qual_s;

  rvq_qual_s s_q;
  rvq_qual_s s_d;
  logic [FLW-1:0] fifo_level;
  logic [IW-1:0] fifo_out;

  rvq_fifo #(
    .WIDTH(IW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(s_q.push),
    .in_ready(),
    .in_data(s_q.push_item),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign out_type = fifo_out[9:8];
  assign out_data = fifo_out[7:0];
  assign reg_rdata = s_q.rdata;
  assign in_ready = s_q.in_ready;
  assign pass = s_q.pass;
  assign pass_lost = s_q.pass_lost;

  always_comb begin
    logic acc;
    logic [1:0] thr;
    logic [1:0] eff_thr;
    logic q_line;
    logic q_lines;
    logic q_par;
    logic discard;
    logic send;
    logic cut;
    logic mism;
    logic par_hit;
    logic pass_n;
    acc = in_valid && s_q.in_ready;
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.pass_lost = 1'b0;
    send = 1'b0;
    cut = 1'b0;
    mism = 1'b0;
    eff_thr = 2'b00;
    pass_n = 1'b0;
    thr = s_q.qual_ctl[`RVQ_THRESH_MSB:`RVQ_THRESH_LSB];
    q_line = s_q.qual_ctl[`RVQ_QUAL_LINE_SIZE_BIT];
    q_lines = s_q.qual_ctl[`RVQ_QUAL_LINES_BIT];
    q_par = s_q.qual_ctl[`RVQ_QUAL_PARITY_BIT];
    discard = s_q.qual_ctl[`RVQ_DISCARD_EN_BIT] && !s_q.pass;
    par_hit = q_par && link_par_err;

    if (reg_wr && reg_addr == `RVQ_TRUNC_CFG_ADDR) begin
      s_d.trunc_cfg = reg_wdata;
    end
    if (reg_wr && reg_addr == `RVQ_QUAL_CTL_ADDR) begin
      s_d.qual_ctl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `RVQ_TRUNC_CFG_ADDR: s_d.rdata = s_q.trunc_cfg;
        `RVQ_QUAL_CTL_ADDR: s_d.rdata = s_q.qual_ctl;
        `RVQ_STATUS_ADDR: begin
          s_d.rdata = {rx_lock, s_q.sticky, s_q.cnt, s_q.pass};
          s_d.sticky = '0;
        end
        default: s_d.rdata = 8'h00;
      endcase
    end

    if (acc) begin
      case (rvq_pkg::rvq_item_e'(in_type))
        rvq_pkg::RVQ_ITEM_FRAME_START: begin
          s_d.in_frame = 1'b1;
          s_d.frame_bad = !rx_lock;
          s_d.line_no = '0;
          s_d.line_len = '0;
          s_d.fwd = !discard;
          send = !discard;
        end
        rvq_pkg::RVQ_ITEM_DATA: begin
          if (s_q.line_len != '1) begin
            s_d.line_len = s_q.line_len + LEN_W'(1);
          end
          send = s_q.fwd;
        end
        rvq_pkg::RVQ_ITEM_LINE_END: begin
          mism = s_q.ref_len_ok && s_q.line_len != s_q.ref_len;
          if (mism) begin
            s_d.sticky[`RVQ_FLG_LINE_LEN] = 1'b1;
            if (q_line) begin
              s_d.cnt = 2'b00;
              s_d.frame_bad = 1'b1;
            end
            cut = s_q.trunc_cfg[`RVQ_TRUNC_LINE_BIT];
          end
          s_d.ref_len = s_q.line_len;
          s_d.ref_len_ok = 1'b1;
          s_d.line_len = '0;
          if (s_q.line_no != '1) begin
            s_d.line_no = s_q.line_no + LINES_W'(1);
          end
          send = s_q.fwd && !cut;
        end
        default: begin
          mism = s_q.ref_lines_ok && s_q.line_no != s_q.ref_lines;
          if (mism) begin
            s_d.sticky[`RVQ_FLG_LINE_CNT] = 1'b1;
            if (q_lines) begin
              s_d.cnt = 2'b00;
              s_d.frame_bad = 1'b1;
            end
            cut = s_q.trunc_cfg[`RVQ_TRUNC_FRAME_BIT];
          end
          s_d.ref_lines = s_q.line_no;
          s_d.ref_lines_ok = 1'b1;
          if (s_q.in_frame && !s_d.frame_bad && s_q.cnt < thr) begin
            s_d.cnt = s_q.cnt + 2'b01;
          end
          send = s_q.fwd && !cut;
          s_d.in_frame = 1'b0;
          s_d.fwd = 1'b0;
        end
      endcase
    end

    if (csi_par_err && s_q.trunc_cfg[`RVQ_TRUNC_CSI_PAR_BIT]) begin
      cut = 1'b1;
      send = 1'b0;
    end
    // stop mid frame when pass drops
    if (discard && s_q.fwd) begin
      cut = 1'b1;
      send = 1'b0;
    end
    if (cut && (s_q.fwd || s_d.fwd)) begin
      s_d.sticky[`RVQ_FLG_TRUNC] = 1'b1;
      s_d.fwd = 1'b0;
    end

    if (link_par_err) begin
      s_d.sticky[`RVQ_FLG_PARITY] = 1'b1;
    end
    if (par_hit) begin
      s_d.cnt = 2'b00;
      s_d.frame_bad = 1'b1;
      s_d.par_recov = 1'b1;
    end
    if (!rx_lock) begin
      s_d.cnt = 2'b00;
      s_d.frame_bad = 1'b1;
      s_d.par_recov = 1'b0;
    end

    eff_thr = thr;
    if (s_d.par_recov && q_par && thr != 2'b00) begin
      eff_thr = thr - 2'b01;
    end
    pass_n = rx_lock && !par_hit && s_d.cnt >= eff_thr;
    // Keep the early threshold until the count catches up, so pass does not fall again.
    if (s_d.cnt >= thr) begin
      s_d.par_recov = 1'b0;
    end
    s_d.pass = pass_n;
    s_d.pass_lost = s_q.pass && !pass_n;

    if (send) begin
      s_d.push = 1'b1;
      s_d.push_item = {in_type, in_data};
    end
    s_d.in_ready = 32'(fifo_level) + 32'(s_q.push) + 32'(acc) <= FIFO_DEPTH - 1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.trunc_cfg <= `RVQ_TRUNC_CFG_RST;
      s_q.qual_ctl <= `RVQ_QUAL_CTL_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rvq_qualifier

// ==== testbench/rvq_qualifier_sva.sv ====
`timescale 1ns/1ps
module rvq_chk #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_lock,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [1:0] out_type,
  input wire logic [7:0] out_data,
  input wire logic pass,
  input wire logic pass_lost
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic fe_q;
  // Remembers that the last item handed downstream closed a frame.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fe_q <= 1'b0;
    end else if (out_valid && out_ready) begin
      fe_q <= out_type == rvq_pkg::RVQ_ITEM_FRAME_END;
    end
  end
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_held;
    out_valid && $stable(out_type) && $stable(out_data);
  endsequence
  out_hold_a: assert property (s_stall |=> s_held) else $error("output moved in stall");
  start_after_end_a: assert property (out_valid && fe_q |->
    out_type == rvq_pkg::RVQ_ITEM_FRAME_START) else $error("no frame start after end");
  lock_drop_a: assert property (!rx_lock |=> !pass) else $error("pass without lock");
  lost_edge_a: assert property ($fell(pass) |-> pass_lost) else $error("fall unflagged");
  lost_cause_a: assert property (pass_lost |-> !pass && $past(pass))
    else $error("flag without fall");
  lost_once_a: assert property (pass_lost |=> !pass_lost) else $error("flag too long");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {8'h7C, 8'h7D, 8'h7E})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule : rvq_chk
bind rvq_qualifier rvq_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk, .rstn, .reg_addr, .reg_rd,
  .reg_rdata, .rx_lock, .out_valid, .out_ready, .out_type, .out_data, .pass, .pass_lost);

// ==== testbench/rvq_sink.sv ====
`timescale 1ns/1ps
module rvq_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic fast,
  output logic out_ready
);
  initial out_ready = 1'b0;
  // Slow mode accepts every other cycle.
  always @(negedge clk) begin
    out_ready <= !stall && (fast || !out_ready);
  end
endmodule : rvq_sink

// ==== testbench/tb_rvq_qualifier.sv ====
`timescale 1ns/1ps
module tb_rvq_qualifier;
  logic clk, rstn, reg_wr, reg_rd, rx_lock, link_par_err, csi_par_err, stall, fast;
  logic in_valid, in_ready, out_valid, out_ready, pass, pass_lost;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, in_data, out_data;
  logic [1:0] in_type, out_type;
  logic [9:0] exp_q[$];
  int n_mismatch, comparisons, seed, lo, np;
  rvq_qualifier dut (.clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rx_lock, .link_par_err, .csi_par_err, .in_valid, .in_ready, .in_type, .in_data,
    .out_valid, .out_ready, .out_type, .out_data, .pass, .pass_lost);
  rvq_sink sink (.clk, .stall, .fast, .out_ready);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task acc(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_rd} = {w, !w};
    {reg_addr, reg_wdata} = {a, d};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask : acc
  task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("reg", {2'b00, reg_rdata & m}, {2'b00, e});
  endtask : rdc
  // Each item is noted before the edge that takes it.
  task put(input logic [1:0] t, input bit f);
    @(negedge clk);
    {in_valid, in_type} = {1'b1, t};
    in_data = t == 2'd0 ? 8'($random(seed)) : 8'h00;
    while (in_ready !== 1'b1) @(negedge clk);
    if (f) exp_q.push_back({t, in_data});
  endtask : put
  task frame(input int n, input int l, input int last, input bit f, input logic [1:0] cut);
    put(2'd1, f);
    for (int i = 1; i <= n; i++) begin
      for (int j = 0; j < (i == n ? last : l); j++) put(2'd0, f);
      put(2'd2, f && !(i == n && cut[0]));
    end
    put(2'd3, f && !cut[1]);
    @(negedge clk);
    in_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : frame
  // Looks just after the sink has decided, so a transfer is seen before the edge that makes it.
  always @(negedge clk) begin
    #1;
    if (rstn && out_valid && out_ready) begin
      chk("out", {out_type, out_data}, exp_q.size() ? exp_q.pop_front() : 10'h3FF);
    end
  end
  // Pass follows its cause by one cycle.
  task pchk(input logic e);
    @(negedge clk);
    chk("pass", pass, e);
  endtask : pchk
  initial begin
    seed = 32'h8028DC1B;
    {rstn, reg_wr, reg_rd, link_par_err, csi_par_err, in_valid, stall} = '0;
    {reg_addr, reg_wdata, in_type, in_data, rx_lock, fast} = {26'h0, 2'b11};
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    rdc(8'h7C, 8'hFF, 8'h00);
    rdc(8'h7D, 8'hFF, 8'h00);
    rdc(8'h40, 8'hFF, 8'h00);
    acc(1'b1, 8'h7C, 8'h07);
    rdc(8'h7C, 8'hFF, 8'h07);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h7D, 8'(i));
      rdc(8'h7D, 8'hFF, 8'(i));
    end
    pchk(1'b0);
    acc(1'b1, 8'h7C, 8'h00);
    acc(1'b1, 8'h7D, 8'h00);
    pchk(1'b1);
    acc(1'b1, 8'h7D, 8'h21);
    pchk(1'b0);
    frame(2, 2, 2, 1'b0, 2'd0);
    pchk(1'b1);
    stall = 1'b1;
    fork
      frame(3, 2, 2, 1'b1, 2'd0);
      begin
        repeat (20) @(negedge clk);
        chk("ready", in_ready, 1'b0);
        stall = 1'b0;
      end
    join
    fast = 1'b0;
    acc(1'b1, 8'h7C, 8'h01);
    acc(1'b1, 8'h7D, 8'h05);
    frame(3, 2, 3, 1'b1, 2'd3);
    pchk(1'b0);
    rdc(8'h7E, 8'h48, 8'h48);
    rdc(8'h7E, 8'h48, 8'h00);
    frame(2, 3, 3, 1'b1, 2'd0);
    pchk(1'b1);
    acc(1'b1, 8'h7C, 8'h03);
    acc(1'b1, 8'h7D, 8'h0D);
    frame(3, 3, 3, 1'b1, 2'd2);
    pchk(1'b0);
    frame(3, 3, 3, 1'b1, 2'd0);
    pchk(1'b1);
    fast = 1'b1;
    acc(1'b1, 8'h7D, 8'h12);
    pchk(1'b0);
    frame(3, 3, 3, 1'b1, 2'd0);
    pchk(1'b1);
    link_par_err = 1'b1;
    @(negedge clk);
    {link_par_err, lo, np} = '0;
    repeat (4) begin
      lo += !pass;
      np += pass_lost;
      @(negedge clk);
    end
    chk("drop", 10'(lo), 10'd4);
    chk("lost", 10'(np), 10'd1);
    frame(3, 3, 3, 1'b1, 2'd0);
    pchk(1'b1);
    rx_lock = 1'b0;
    repeat (2) @(negedge clk);
    pchk(1'b0);
    rx_lock = 1'b1;
    repeat (3) @(negedge clk);
    pchk(1'b0);
    frame(3, 3, 3, 1'b1, 2'd0);
    pchk(1'b0);
    frame(3, 3, 3, 1'b1, 2'd0);
    pchk(1'b1);
    rdc(8'h7E, 8'h01, 8'h01);
    // CSI parity cut: the second data byte and the rest of the frame are dropped.
    acc(1'b1, 8'h7C, 8'h04);
    put(2'd1, 1'b1);
    put(2'd0, 1'b1);
    put(2'd0, 1'b0);
    csi_par_err = 1'b1;
    put(2'd2, 1'b0);
    csi_par_err = 1'b0;
    put(2'd3, 1'b0);
    @(negedge clk);
    in_valid = 1'b0;
    repeat (4) @(negedge clk);
    rdc(8'h7E, 8'h40, 8'h40);
    chk("left", 10'(exp_q.size()), 10'd0);
    stop_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : tb_rvq_qualifier
